// [rtl/pca_counter_array.sv]
// Programmable counter array: counter, timebase, overflow, three capture modules
//
// Summary of operation
// (RQ1) Counter is 16 bits, two visible bytes.
// (RQ2) Low byte read snapshots high byte.
// (RQ3) Byte reads never disturb counting.
// (RQ4) Timebase select picks one of six sources.
// (RQ5) Count input falls no faster than quarter clock.
// (RQ6) Oscillator over eight synchronised before use.
// (RQ7) Wrap from FFFF sets overflow flag.
// (RQ8) Overflow interrupt needs overflow enable.
// (RQ9) Overflow flag cleared only by software.
// (RQ10) Requests need global and array enables.
// (RQ11) Idle halt clear keeps counting in idle.
// (RQ12) Three modules, 16-bit register, own line.
// (RQ13) Capture mode decode from edge bits.
// (RQ14) Mode register decodes compare and pwm modes.
// (RQ15) Module interrupt needs module enable.
// (RQ16) Capture loads counter into module register.
// (RQ17) Capture sets event flag, may interrupt.
// (RQ18) Event flag cleared only by software.
// (RQ19) Module line state stays readable.
// (RQ20) Line levels held two clocks minimum.
// (RQ21) Module 2 starts in watchdog mode, writes restricted.
// (RQ22) Low write clears, high write sets comparator.
// (RQ23) Count per tick, lines synchronised first.
`include "pca_map.svh"
module pca_counter_array #(
    parameter int NUM_MOD = 3
) (
    input wire logic core_clk,
    input wire logic srst,
    // Software access strobes
    input wire logic rd_count_low,
    input wire logic rd_count_high,
    input wire logic wr_count_low,
    input wire logic wr_count_high,
    input wire logic [7:0] wr_data,
    output logic [7:0] count_low_byte,
    output logic [7:0] count_high_byte,
    // Configuration bits
    input wire logic count_run,
    input wire logic [2:0] timebase_select,
    input wire logic idle_halt_select,
    input wire logic cpu_idle,
    input wire logic overflow_irq_enable,
    input wire logic global_irq_enable,
    input wire logic array_irq_enable,
    input wire logic watchdog_enable,
    input wire logic timer0_overflow,
    // Pins from outside the clock domain
    input wire logic external_count_input,
    input wire logic ext_osc_div8,
    input wire logic [NUM_MOD-1:0] module_io_line,
    // Module register access
    input wire logic [NUM_MOD-1:0] wr_mode,
    input wire logic [NUM_MOD-1:0] wr_cap_low,
    input wire logic [NUM_MOD-1:0] wr_cap_high,
    input wire logic clr_overflow,
    input wire logic [NUM_MOD-1:0] clr_event,
    output logic [NUM_MOD*8-1:0] module_mode_reg,
    output logic [NUM_MOD*16-1:0] capture_value,
    output logic [NUM_MOD-1:0] module_event_flag,
    output logic [NUM_MOD-1:0] module_line_state,
    output logic [NUM_MOD*3-1:0] module_mode,
    output logic count_overflow_flag,
    output logic array_irq
);
    import pca_pkg::*;
    // Refused at elaboration; module 2 must exist for the watchdog
    if (NUM_MOD < 3 || NUM_MOD > 8) begin : g_num_mod_check
        $error("NUM_MOD must be 3 to 8");
    end

    // ======================================================================
    // Pin synchronisers
    logic [2:0] eci_sync; // Count input, bits 0,1 sync, 2 history
    logic [2:0] osc_sync; // Oscillator over eight, same layout
    logic [NUM_MOD-1:0] line_meta; // First flop of module lines
    logic [NUM_MOD-1:0] line_sync; // Second flop of module lines
    // Two-flop synchronisers, third flop for count input and oscillator edge history
    always_ff @(posedge core_clk) begin
        if (srst) begin
            eci_sync <= 3'h0;
            osc_sync <= 3'h0;
            line_meta <= '0;
            line_sync <= '0;
        end else begin
            eci_sync <= {eci_sync[1:0], external_count_input};
            osc_sync <= {osc_sync[1:0], ext_osc_div8}; // [RQ6]
            line_meta <= module_io_line; // [RQ23]
            line_sync <= line_meta;
        end
    end

    // ======================================================================
    // Timebase
    logic [3:0] pre12; // Divide by twelve prescaler
    logic [1:0] pre4; // Divide by four prescaler
    logic tick; // Selected timebase edge
    logic run_now; // Counting allowed this cycle
    // Free-running prescalers
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pre12 <= 4'h0;
            pre4 <= 2'h0;
        end else begin
            pre12 <= (pre12 == `PCA_DIV12_LAST) ? 4'h0 : pre12 + 4'h1;
            pre4 <= pre4 + 2'h1;
        end
    end

    // Source mux; count input uses falling edges, oscillator rising edges
    always_comb begin
        case (timebase_select) // [RQ4]
            `PCA_TB_DIV12: tick = (pre12 == `PCA_DIV12_LAST);
            `PCA_TB_DIV4: tick = (pre4 == 2'(`PCA_DIV4_LAST));
            `PCA_TB_T0OVF: tick = timer0_overflow;
            `PCA_TB_ECI: tick = eci_sync[2] & ~eci_sync[1]; // [RQ5]
            `PCA_TB_SYS: tick = 1'b1;
            `PCA_TB_EXT8: tick = osc_sync[1] & ~osc_sync[2]; // [RQ6]
            default: tick = 1'b0;
        endcase
    end

    // Watchdog forces counting on; idle halts only when selected
    assign run_now = (count_run | watchdog_enable)
        & ~(cpu_idle & idle_halt_select); // [RQ11]

    // ======================================================================
    // Counter
    pca_count_t count; // Live count
    logic [7:0] snap_high; // High byte snapshot
    logic count_wrap; // Wrap this cycle
    assign count_wrap = run_now & tick & (count == `PCA_COUNT_MAX);
    // Counter; writes blocked while the watchdog runs
    always_ff @(posedge core_clk) begin
        if (srst) begin
            count <= `PCA_COUNT_RESET;
        end else if (wr_count_low && !watchdog_enable) begin // [RQ21]
            count[7:0] <= wr_data;
        end else if (wr_count_high && !watchdog_enable) begin
            count[15:8] <= wr_data;
        end else if (run_now && tick) begin
            count <= count + 16'h0001; // [RQ23] [RQ3]
        end
    end

    // Snapshot of high byte on low read
    always_ff @(posedge core_clk) begin
        if (srst) begin
            snap_high <= 8'h00;
        end else if (rd_count_low) begin
            snap_high <= count[15:8]; // [RQ2]
        end
    end

    // Registered read data; high read returns the snapshot
    always_ff @(posedge core_clk) begin
        if (srst) begin
            count_low_byte <= 8'h00;
            count_high_byte <= 8'h00;
        end else begin
            count_low_byte <= count[7:0]; // [RQ1]
            count_high_byte <= rd_count_low ? count[15:8] : snap_high; // [RQ2]
        end
    end

    // Overflow flag, set wins over clear
    always_ff @(posedge core_clk) begin
        if (srst) begin
            count_overflow_flag <= 1'b0;
        end else if (count_wrap) begin
            count_overflow_flag <= 1'b1; // [RQ7]
        end else if (clr_overflow) begin
            count_overflow_flag <= 1'b0; // [RQ9]
        end
    end

    // ======================================================================
    // Modules
    logic [NUM_MOD-1:0] cap_pulse; // Capture pulses
    logic [7:0] mm [NUM_MOD]; // Mode registers
    logic [15:0] ccr [NUM_MOD]; // Capture/compare registers
    for (genvar m = 0; m < NUM_MOD; m++) begin : g_mod
        pca_cap_if cif ();
        assign cif.count = count;
        assign cif.mode = mm[m];
        assign cif.line_sync = line_sync[m];
        assign cap_pulse[m] = cif.capture;
        pca_cap_detect u_det (
            .core_clk(core_clk),
            .srst(srst),
            .cif(cif)
        );
        // Mode register; watchdog module starts in timer mode, mode writes refused while the watchdog runs
        always_ff @(posedge core_clk) begin
            if (srst) begin
                if (m == `PCA_WDOG_MODULE) begin
                    mm[m] <= `PCA_WDOG_MODE_RESET; // [RQ21]
                end else begin
                    mm[m] <= `PCA_MM_RESET;
                end
            end else if (wr_mode[m] && !(watchdog_enable && m == `PCA_WDOG_MODULE)) begin
                mm[m] <= wr_data; // [RQ21]
            end else if (wr_cap_low[m]) begin
                mm[m][`PCA_MM_COMP] <= 1'b0; // [RQ22]
            end else if (wr_cap_high[m]) begin
                mm[m][`PCA_MM_COMP] <= 1'b1; // [RQ22]
            end
        end
        // Capture/compare register; capture has priority over writes
        always_ff @(posedge core_clk) begin
            if (srst) begin
                ccr[m] <= 16'h0000;
            end else if (cap_pulse[m]) begin
                ccr[m] <= count; // [RQ16] [RQ12]
            end else if (wr_cap_low[m]) begin
                ccr[m][7:0] <= wr_data;
            end else if (wr_cap_high[m]) begin
                ccr[m][15:8] <= wr_data;
            end
        end
        // Event flag, set wins over clear
        always_ff @(posedge core_clk) begin
            if (srst) begin
                module_event_flag[m] <= 1'b0;
            end else if (cap_pulse[m]) begin
                module_event_flag[m] <= 1'b1; // [RQ17]
            end else if (clr_event[m]) begin
                module_event_flag[m] <= 1'b0; // [RQ18]
            end
        end
        // Mode decode
        always_ff @(posedge core_clk) begin
            if (srst) begin
                module_mode[m*3 +: 3] <= PCA_MODE_OFF;
            end else begin
                module_mode[m*3 +: 3] <= decode_mode(mm[m]); // [RQ14]
            end
        end
        // Registered views for software
        always_ff @(posedge core_clk) begin
            if (srst) begin
                module_mode_reg[m*8 +: 8] <= 8'h00;
                capture_value[m*16 +: 16] <= 16'h0000;
                module_line_state[m] <= 1'b0;
            end else begin
                module_mode_reg[m*8 +: 8] <= mm[m];
                capture_value[m*16 +: 16] <= ccr[m];
                module_line_state[m] <= line_sync[m]; // [RQ19]
            end
        end
    end

    // Mode table lookup; capture checked first
    function automatic pca_mode_e decode_mode(input logic [7:0] r);
        pca_mode_e md;
        md = PCA_MODE_OFF;
        if (!r[`PCA_MM_MAT] && !r[`PCA_MM_TOG] && !r[`PCA_MM_PULSE]
            && (r[`PCA_MM_RISE] || r[`PCA_MM_FALL])) begin
            md = PCA_MODE_CAPTURE;
        end else if (r[`PCA_MM_COMP] && !r[`PCA_MM_RISE] && !r[`PCA_MM_FALL]) begin
            case ({r[`PCA_MM_MAT], r[`PCA_MM_TOG], r[`PCA_MM_PULSE]})
                3'b100: md = PCA_MODE_SWTIMER;
                3'b110: md = PCA_MODE_HSOUT;
                3'b011, 3'b111: md = PCA_MODE_FREQ;
                3'b001, 3'b101: md = r[`PCA_MM_WIDE] ? PCA_MODE_PWM16 : PCA_MODE_PWM8;
                default: md = PCA_MODE_OFF;
            endcase
        end
        return md;
    endfunction

    // ======================================================================
    // Interrupt request
    logic [NUM_MOD-1:0] mod_req; // Enabled module flags
    always_comb begin
        for (int i = 0; i < NUM_MOD; i++) begin
            mod_req[i] = module_event_flag[i] & mm[i][`PCA_MM_IRQ]; // [RQ15]
        end
    end

    // Combined request gated by both global enables
    always_ff @(posedge core_clk) begin
        if (srst) begin
            array_irq <= 1'b0;
        end else begin
            array_irq <= global_irq_enable & array_irq_enable & // [RQ10]
                ((count_overflow_flag & overflow_irq_enable) | (|mod_req)); // [RQ8]
        end
    end

    // ======================================================================
    // Checks
    a_wrap_sets_flag: assert property (@(posedge core_clk) disable iff (srst) // [RQ7]
        count_wrap |=> count_overflow_flag)
        else $error("wrap did not set overflow flag");
    a_flag_holds: assert property (@(posedge core_clk) disable iff (srst) // [RQ9]
        (count_overflow_flag && !clr_overflow) |=> count_overflow_flag)
        else $error("overflow flag lost without clear");
    a_snap_read: assert property (@(posedge core_clk) disable iff (srst) // [RQ2]
        rd_count_low ##1 (!rd_count_low && !srst)
        |=> count_high_byte == $past(count[15:8], 2))
        else $error("high byte not from snapshot");
    a_irq_gate: assert property (@(posedge core_clk) disable iff (srst) // [RQ10]
        !global_irq_enable |=> !array_irq)
        else $error("request without global enable");
    a_ovf_irq: assert property (@(posedge core_clk) disable iff (srst) // [RQ8]
        (global_irq_enable && array_irq_enable && overflow_irq_enable
        && count_overflow_flag) |=> array_irq)
        else $error("overflow request missing");
    a_cap_load: assert property (@(posedge core_clk) disable iff (srst) // [RQ16] [RQ17]
        cap_pulse[0] |=> (ccr[0] == $past(count) && module_event_flag[0]))
        else $error("capture did not load counter");
    a_event_hold: assert property (@(posedge core_clk) disable iff (srst) // [RQ18]
        (module_event_flag[1] && !clr_event[1]) |=> module_event_flag[1])
        else $error("event flag lost without clear");
    a_idle_count: assert property (@(posedge core_clk) disable iff (srst) // [RQ11]
        (count_run && !idle_halt_select && timebase_select == `PCA_TB_SYS
        && !wr_count_low && !wr_count_high) |=> count == $past(count) + 16'h0001)
        else $error("counter stalled");
    a_low_clears_comp: assert property (@(posedge core_clk) disable iff (srst) // [RQ22]
        (wr_cap_low[0] && !wr_mode[0]) |=> !mm[0][`PCA_MM_COMP])
        else $error("low write kept comparator");
    a_wdog_lock: assert property (@(posedge core_clk) disable iff (srst) // [RQ21]
        watchdog_enable |=> $stable(mm[2]) || $past(wr_cap_low[2] || wr_cap_high[2]))
        else $error("watchdog mode register changed");
    a_read_no_stall: assert property (@(posedge core_clk) disable iff (srst) // [RQ3]
        ((rd_count_low || rd_count_high) && run_now && tick
        && !wr_count_low && !wr_count_high) |=> count == $past(count) + 16'h0001)
        else $error("read stalled counter");
    a_wdog_write_lock: assert property (@(posedge core_clk) disable iff (srst) // [RQ21]
        (watchdog_enable && (wr_count_low || wr_count_high) && tick)
        |=> count == $past(count) + 16'h0001)
        else $error("counter write under watchdog");
    c_fall_capture: cover property (@(posedge core_clk)
        cap_pulse[0] && !line_sync[0]);
    c_overflow: cover property (@(posedge core_clk) count_wrap);
    c_capture: cover property (@(posedge core_clk) |cap_pulse);
    c_irq: cover property (@(posedge core_clk) array_irq);
    c_eci_tick: cover property (@(posedge core_clk)
        timebase_select == `PCA_TB_ECI && tick);
endmodule

// [rtl/pca_map.svh]
// Constants for the counter array: field positions, reset values and timing counts
`ifndef PCA_MAP_SVH
`define PCA_MAP_SVH
// ==========================================================================
// Timebase select encodings
`define PCA_TB_DIV12 3'h0
`define PCA_TB_DIV4 3'h1
`define PCA_TB_T0OVF 3'h2
`define PCA_TB_ECI 3'h3
`define PCA_TB_SYS 3'h4
`define PCA_TB_EXT8 3'h5
// ==========================================================================
// Prescaler terminal counts
`define PCA_DIV12_LAST 4'hB
`define PCA_DIV4_LAST 4'h3
// ==========================================================================
// Module mode register field positions
`define PCA_MM_IRQ 0
`define PCA_MM_PULSE 1
`define PCA_MM_TOG 2
`define PCA_MM_MAT 3
`define PCA_MM_FALL 4
`define PCA_MM_RISE 5
`define PCA_MM_COMP 6
`define PCA_MM_WIDE 7
// ==========================================================================
// Reset values, counter maximum and watchdog module number
`define PCA_MM_RESET 8'h00
`define PCA_WDOG_MODE_RESET 8'h48
`define PCA_COUNT_RESET 16'h0000
`define PCA_COUNT_MAX 16'hFFFF
`define PCA_WDOG_MODULE 2
`endif

// [rtl/pca_pkg.sv]
// Types shared by the counter array modules
package pca_pkg;
    // Decoded module operating mode
    typedef enum logic [2:0] {
        PCA_MODE_OFF = 3'b000,
        PCA_MODE_CAPTURE = 3'b001,
        PCA_MODE_SWTIMER = 3'b010,
        PCA_MODE_HSOUT = 3'b011,
        PCA_MODE_FREQ = 3'b100,
        PCA_MODE_PWM8 = 3'b101,
        PCA_MODE_PWM16 = 3'b110
    } pca_mode_e;
    typedef logic [15:0] pca_count_t;
endpackage

// [rtl/pca_cap_if.sv]
// Carrier between the counter core and one capture module
interface pca_cap_if;
    logic [15:0] count; // Live counter value
    logic [7:0] mode; // Module mode register
    logic line_sync; // Synchronised module line
    logic capture; // One-cycle capture pulse
    modport core (output count, output mode, output line_sync, input capture);
    modport cap (input count, input mode, input line_sync, output capture);
endinterface

// [rtl/pca_cap_detect.sv]
// Edge detector and capture decision for one capture module
`include "pca_map.svh"
module pca_cap_detect (
    input wire logic core_clk,
    input wire logic srst,
    pca_cap_if.cap cif
);
    import pca_pkg::*;
    logic line_prev; // Line one cycle ago
    logic rise_sel; // Rising edge chosen
    logic fall_sel; // Falling edge chosen
    logic cap_mode; // Match, toggle, pulse all clear
    // ======================================================================
    // Mode decode
    assign rise_sel = cif.mode[`PCA_MM_RISE];
    assign fall_sel = cif.mode[`PCA_MM_FALL];
    assign cap_mode = ~cif.mode[`PCA_MM_MAT] & ~cif.mode[`PCA_MM_TOG]
        & ~cif.mode[`PCA_MM_PULSE]; // [RQ13]
    // Previous line value for edge detection
    always_ff @(posedge core_clk) begin
        if (srst) begin
            line_prev <= 1'b0;
        end else begin
            line_prev <= cif.line_sync;
        end
    end
    // Selected edge raises a capture pulse
    assign cif.capture = cap_mode & (
        (rise_sel & cif.line_sync & ~line_prev) |
        (fall_sel & ~cif.line_sync & line_prev)); // [RQ13] [RQ16]
    // ======================================================================
    // Checks
    a_rise_capture: assert property (@(posedge core_clk) disable iff (srst) // [RQ13]
        (cap_mode && rise_sel && $rose(cif.line_sync)) |-> cif.capture)
        else $error("rising edge not captured");
    a_no_cap_other: assert property (@(posedge core_clk) disable iff (srst) // [RQ13]
        cif.mode[`PCA_MM_MAT] |-> !cif.capture)
        else $error("capture outside capture mode");
endmodule

// [testbench/pca_line_model.sv]
// Far-side model: module lines, external count input and divided oscillator
module pca_line_model (
    input wire logic core_clk,
    output logic [2:0] module_io_line,
    output logic external_count_input,
    output logic ext_osc_div8
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Idle levels: count input rests high, oscillator low
    initial begin
        module_io_line = 3'h0;
        external_count_input = 1'b1;
        ext_osc_div8 = 1'b0;
    end
    // ==========================================
    // Line change, then held three clocks so the level is seen
    task automatic set_line(input int n, input logic v);
        @(negedge core_clk);
        module_io_line[n] = v;
        repeat (3) @(negedge core_clk);
    endtask
    // Edge trains four clocks per half, well under quarter rate
    task automatic pulses(input logic osc, input int n);
        repeat (n) begin
            if (osc) begin
                ext_osc_div8 = 1'b1;
            end else begin
                external_count_input = 1'b0;
            end
            repeat (4) @(negedge core_clk);
            ext_osc_div8 = 1'b0;
            external_count_input = 1'b1;
            repeat (4) @(negedge core_clk);
        end
    endtask
endmodule

// [testbench/pca_counter_array_bench.sv]
// Self-checking bench for the programmable counter array
module pca_counter_array_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import pca_pkg::*;
    // ==========================================
    // Driven inputs, all given a value at time zero
    logic core_clk = 1'b0, srst = 1'b1, rd_count_low = 1'b0, rd_count_high = 1'b0;
    logic wr_count_low = 1'b0, wr_count_high = 1'b0, count_run = 1'b0;
    logic [7:0] wr_data = 8'h00;
    logic [2:0] timebase_select = 3'h4;
    logic idle_halt_select = 1'b0, cpu_idle = 1'b0, timer0_overflow = 1'b0;
    logic overflow_irq_enable = 1'b0, global_irq_enable = 1'b0, array_irq_enable = 1'b0;
    logic watchdog_enable = 1'b0, clr_overflow = 1'b0;
    logic [2:0] wr_mode = 3'h0, wr_cap_low = 3'h0, wr_cap_high = 3'h0, clr_event = 3'h0;
    // Observed outputs and model pins
    logic [7:0] count_low_byte, count_high_byte;
    logic [23:0] module_mode_reg;
    logic [47:0] capture_value;
    logic [2:0] module_event_flag, module_line_state, module_io_line;
    logic [8:0] module_mode;
    logic count_overflow_flag, array_irq, external_count_input, ext_osc_div8;
    int errors = 0, num_checks = 0, k;
    logic [15:0] v;
    // Mode byte beside the decoded mode it must give
    typedef struct packed {logic [7:0] mode_byte; logic [2:0] expect_mode;} pca_row_s;
    pca_row_s rows [9] = '{'{8'h20, 3'h1}, '{8'h10, 3'h1}, '{8'h31, 3'h1}, '{8'h48, 3'h2},
        '{8'h4C, 3'h3}, '{8'h46, 3'h4}, '{8'h42, 3'h5}, '{8'hC2, 3'h6}, '{8'h00, 3'h0}};
    // Timebase selects and their divide ratios
    logic [2:0] tb_sel [3] = '{3'h4, 3'h1, 3'h0};
    int tb_div [3] = '{1, 4, 12};
    // ==========================================
    // Design and far-side model
    pca_counter_array dut_u (
        .core_clk, .srst, .rd_count_low, .rd_count_high, .wr_count_low, .wr_count_high,
        .wr_data, .count_low_byte, .count_high_byte, .count_run, .timebase_select,
        .idle_halt_select, .cpu_idle, .overflow_irq_enable, .global_irq_enable,
        .array_irq_enable, .watchdog_enable, .timer0_overflow, .external_count_input,
        .ext_osc_div8, .module_io_line, .wr_mode, .wr_cap_low, .wr_cap_high, .clr_overflow,
        .clr_event, .module_mode_reg, .capture_value, .module_event_flag,
        .module_line_state, .module_mode, .count_overflow_flag, .array_irq
    );
    pca_line_model line_u (.core_clk, .module_io_line, .external_count_input, .ext_osc_div8);
    // ==========================================
    // Clock at 100 MHz
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    // ==========================================
    // Helpers; every strobe is raised and dropped on falling edges
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic set_mode(input int n, input logic [7:0] d);
        wr_data = d;
        wr_mode[n] = 1'b1;
        tick(1);
        wr_mode[n] = 1'b0;
        tick(1);
    endtask
    // Low byte first, then high, then let the write settle
    task automatic set_count(input logic [15:0] c);
        wr_data = c[7:0];
        wr_count_low = 1'b1;
        tick(1);
        wr_count_low = 1'b0;
        wr_data = c[15:8];
        wr_count_high = 1'b1;
        tick(1);
        wr_count_high = 1'b0;
        tick(1);
    endtask
    // Low read snapshots the high byte; the low byte is taken one cycle later, at the high read
    task automatic read_count(output logic [15:0] c);
        rd_count_low = 1'b1;
        tick(1);
        rd_count_low = 1'b0;
        rd_count_high = 1'b1;
        tick(1);
        rd_count_high = 1'b0;
        c = {count_high_byte, count_low_byte};
    endtask
    task automatic clear_event(input int n);
        clr_event[n] = 1'b1;
        tick(1);
        clr_event[n] = 1'b0;
        tick(2);
    endtask
    task automatic check_reset();
        check({count_high_byte, count_low_byte}, 16'h0000);
        check(module_mode_reg, 24'h480000);
        check(module_mode, 9'h080);
        check({module_event_flag, count_overflow_flag, array_irq}, 5'h00);
    endtask
    task automatic finish_test();
        if (errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ==========================================
    // Watchdog: the whole sequence needs a few hundred clocks at most
    initial begin
        #50us;
        errors++;
        finish_test();
    end
    // ==========================================
    // Main sequence
    initial begin
        tick(3);
        srst = 1'b0;
        tick(1);
        check_reset();
        // Mode decode rows on module 0
        foreach (rows[i]) begin
            set_mode(0, rows[i].mode_byte);
            check(module_mode_reg[7:0], rows[i].mode_byte);
            check(module_mode[2:0], rows[i].expect_mode);
        end
        // Snapshot holds while the counter moves on
        set_count(16'h34FE);
        read_count(v);
        check(v, 16'h34FE);
        count_run = 1'b1;
        tick(4);
        count_run = 1'b0;
        tick(2);
        check(count_high_byte, 8'h34);
        read_count(v);
        check(v, 16'h3502);
        // System clock undivided, by four and by twelve; idle without halt must keep counting
        cpu_idle = 1'b1;
        foreach (tb_sel[i]) begin
            set_count(16'h0000);
            timebase_select = tb_sel[i];
            count_run = 1'b1;
            tick(48);
            count_run = 1'b0;
            tick(2);
            read_count(v);
            check(v, 16'(48 / tb_div[i]));
        end
        // Edge-driven sources: five events each
        foreach (tb_div[i]) begin
            set_count(16'h0000);
            timebase_select = (i == 0) ? 3'h2 : ((i == 1) ? 3'h3 : 3'h5);
            count_run = 1'b1;
            for (k = 0; k < 5 && i == 0; k++) begin
                timer0_overflow = 1'b1;
                tick(1);
                timer0_overflow = 1'b0;
                tick(1);
            end
            if (i != 0) line_u.pulses(i == 2, 5);
            tick(8);
            count_run = 1'b0;
            read_count(v);
            check(v, 16'h0005);
        end
        // Wrap sets the flag; request follows the enables
        timebase_select = 3'h4;
        set_count(16'hFFFD);
        {overflow_irq_enable, global_irq_enable, array_irq_enable} = 3'h7;
        count_run = 1'b1;
        for (k = 0; k < 8 && count_overflow_flag !== 1'b1; k++) tick(1);
        count_run = 1'b0;
        tick(2);
        check({count_overflow_flag, array_irq}, 2'h3);
        global_irq_enable = 1'b0;
        tick(2);
        check(array_irq, 1'b0);
        {global_irq_enable, overflow_irq_enable} = 2'h2;
        tick(2);
        check({count_overflow_flag, array_irq}, 2'h2);
        clr_overflow = 1'b1;
        tick(1);
        clr_overflow = 1'b0;
        tick(2);
        check(count_overflow_flag, 1'b0);
        // Capture on each module: rising only, then both edges without irq
        for (int n = 0; n < 3; n++) begin
            set_count(16'hA0C0 + 16'(n));
            set_mode(n, 8'h21);
            line_u.set_line(n, 1'b1);
            tick(3);
            check(capture_value[16*n +: 16], 16'hA0C0 + 16'(n));
            check({module_event_flag[n], array_irq}, 2'h3);
            check(module_line_state[n], 1'b1);
            clear_event(n);
            check({module_event_flag[n], array_irq}, 2'h0);
            line_u.set_line(n, 1'b0);
            tick(3);
            check(module_event_flag[n], 1'b0);
            set_count(16'h5678);
            set_mode(n, 8'h30);
            line_u.set_line(n, 1'b1);
            tick(3);
            check({module_event_flag[n], array_irq}, 2'h2);
            check(capture_value[16*n +: 16], 16'h5678);
            clear_event(n);
            line_u.set_line(n, 1'b0);
            tick(3);
            check({module_event_flag[n], module_line_state[n]}, 2'h2);
        end
        // Capture byte writes switch the comparator off, then on
        set_mode(0, 8'h48);
        wr_cap_low[0] = 1'b1;
        tick(1);
        wr_cap_low[0] = 1'b0;
        tick(1);
        check(module_mode_reg[6], 1'b0);
        wr_cap_high[0] = 1'b1;
        tick(1);
        wr_cap_high[0] = 1'b0;
        tick(1);
        check(module_mode_reg[6], 1'b1);
        // Second reset, then writes refused under the watchdog lock
        srst = 1'b1;
        tick(2);
        srst = 1'b0;
        tick(1);
        check_reset();
        watchdog_enable = 1'b1;
        set_mode(2, 8'h00);
        check(module_mode_reg[23:16], 8'h48);
        set_count(16'h8080);
        read_count(v);
        check(v[15:8], 8'h00);
        finish_test();
    end
endmodule
